// ---- i2ccs_pkg.sv ----
// transfer-clock select package: register map, field positions, reset values, timing
// assumes a single 250 MHz hclk domain that also serves as the peripheral clock
`default_nettype none

package i2ccs_pkg;

  // ********************************************************
  // register map (byte addresses, one aligned word each)
  // ********************************************************
  localparam logic [15:0] CLK_SEL_OFFSET = 16'h0000;
  localparam logic [15:0] IF_CTRL_OFFSET = 16'h0004;
  localparam logic [15:0] CLK_EXP_OFFSET = 16'hFFB4;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CLK_LEVEL_BIT = 5;
  localparam int DATA_LEVEL_BIT = 4;
  localparam int SPEED_MODE_BIT = 3;
  localparam int FILTER_EN_BIT = 2;
  localparam int DIV_HIGH_BIT = 1;
  localparam int DIV_LOW_BIT = 0;
  localparam int DIV_EXP_BIT = 0;
  localparam int IF_ENABLE_BIT = 7;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] CLK_EXP_RESET = 8'h00;
  localparam logic [7:0] IF_CTRL_RESET = 8'h00;

  // ********************************************************
  // timing
  // ********************************************************
  // noise filter: a line level must hold this long before it is accepted
  localparam int FILTER_NS = 12;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [2:0] FILTER_CYCLES = 3'((FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] PRE_DIV2 = 3'h2;
  localparam logic [2:0] PRE_DIV4 = 3'h4;
  localparam logic [5:0] HALF_STD_44 = 6'h16;
  localparam logic [5:0] HALF_STD_86 = 6'h2B;
  localparam logic [5:0] HALF_HS_24 = 6'h0C;
  localparam logic [5:0] HALF_HS_12 = 6'h06;

  typedef struct packed {
    logic div_expansion;
    logic speed_mode_select;
    logic noise_filter_enable;
    logic divide_code_high;
    logic divide_code_low;
  } i2ccs_cfg_t;

  typedef struct packed {
    logic valid;
    logic [2:0] prediv;
    logic [5:0] half;
  } i2ccs_div_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW = 2'b01,
    PH_HIGH = 2'b11
  } i2ccs_phase_t;

endpackage

`default_nettype wire

// ---- i2ccs_top.sv ----
// transfer-clock selection, serial clock generation and line-level sensing
// assumes an AHB-Lite master as the only initiator and open-drain lines with pull-ups
// Behaviour
// - reset clears clock selection: standard mode, filter off, divide code 00
// - reset clears expansion register; only bit 0 exists, others read zero
// - bit 5 shows clock line level when enabled, zero otherwise
// - bit 4 shows data line level when enabled, zero otherwise
// - bits 5 and 4 read-only; bits 7 and 6 read zero
// - bit 3 picks standard mode (0) or high-speed mode (1)
// - bit 2 enables the input noise filter, usable only in high-speed
// - in high-speed mode the filter bit never changes the clock frequency
// - serial clock period is m selection-clock cycles, m from a fixed set
// - standard mode: 00 /2 by 44, 01 /2 by 86, 10 /4 by 86, 11 prohibited
// - high-speed: /2 or /4 by 24, or by 12 with expansion; 11 prohibited
// - disabling stops operation and forces the line-level bits to zero
`default_nettype none

module i2ccs_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial lines, open drain
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_i
);

  // ********************************************************
  // registers
  // ********************************************************
  i2ccs_pkg::i2ccs_cfg_t cfg_r, cfg_nxt;
  logic enable_r, enable_nxt;
  logic wr_pend_r;
  logic [15:0] wr_addr_r;
  logic addr_phase;
  logic clock_line_level_r, data_line_level_r;

  function automatic i2ccs_pkg::i2ccs_div_t decode_div(input i2ccs_pkg::i2ccs_cfg_t c);
    i2ccs_pkg::i2ccs_div_t d;
    d.valid = 1'b1;
    d.prediv = c.divide_code_high ? i2ccs_pkg::PRE_DIV4 : i2ccs_pkg::PRE_DIV2;
    d.half = i2ccs_pkg::HALF_STD_44;
    if (c.divide_code_high && c.divide_code_low) begin
      d.valid = 1'b0;
    end else if (!c.speed_mode_select) begin
      d.valid = !c.div_expansion;
      d.half = (c.divide_code_high || c.divide_code_low) ? i2ccs_pkg::HALF_STD_86 : i2ccs_pkg::HALF_STD_44;
    end else begin
      d.half = c.div_expansion ? i2ccs_pkg::HALF_HS_12 : i2ccs_pkg::HALF_HS_24;
    end
    return d;
  endfunction

  function automatic logic [7:0] read_mux(input logic [15:0] a, input i2ccs_pkg::i2ccs_cfg_t c,
                                          input logic en, input logic cl, input logic dl);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      i2ccs_pkg::CLK_SEL_OFFSET: begin
        v[i2ccs_pkg::CLK_LEVEL_BIT] = cl;
        v[i2ccs_pkg::DATA_LEVEL_BIT] = dl;
        v[i2ccs_pkg::SPEED_MODE_BIT] = c.speed_mode_select;
        v[i2ccs_pkg::FILTER_EN_BIT] = c.noise_filter_enable;
        v[i2ccs_pkg::DIV_HIGH_BIT] = c.divide_code_high;
        v[i2ccs_pkg::DIV_LOW_BIT] = c.divide_code_low;
      end
      i2ccs_pkg::CLK_EXP_OFFSET: v[i2ccs_pkg::DIV_EXP_BIT] = c.div_expansion;
      i2ccs_pkg::IF_CTRL_OFFSET: v[i2ccs_pkg::IF_ENABLE_BIT] = en;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ********************************************************
  // ahb-lite slave, zero wait states
  // ********************************************************
  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_r <= haddr;
      end
    end
  end

  // writes land in the data phase; bits 7..4 of clock selection have no storage
  always_comb begin
    cfg_nxt = cfg_r;
    enable_nxt = enable_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        i2ccs_pkg::CLK_SEL_OFFSET: begin
          cfg_nxt.speed_mode_select = hwdata[i2ccs_pkg::SPEED_MODE_BIT];
          cfg_nxt.noise_filter_enable = hwdata[i2ccs_pkg::FILTER_EN_BIT];
          cfg_nxt.divide_code_high = hwdata[i2ccs_pkg::DIV_HIGH_BIT];
          cfg_nxt.divide_code_low = hwdata[i2ccs_pkg::DIV_LOW_BIT];
        end
        i2ccs_pkg::CLK_EXP_OFFSET: cfg_nxt.div_expansion = hwdata[i2ccs_pkg::DIV_EXP_BIT];
        i2ccs_pkg::IF_CTRL_OFFSET: enable_nxt = hwdata[i2ccs_pkg::IF_ENABLE_BIT];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= '0;
      enable_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      enable_r <= enable_nxt;
    end
  end

  // read data is taken from next values so a read right after a write sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= {24'h00_0000, read_mux(haddr, cfg_nxt, enable_nxt,
                                         clock_line_level_r && enable_nxt, data_line_level_r && enable_nxt)};
      end
    end
  end

  // ********************************************************
  // line sampling and noise filter
  // ********************************************************
  logic [1:0] scl_sync_r, sda_sync_r;
  logic [2:0] scl_stab_r, sda_stab_r;
  logic filter_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
    end else begin
      scl_sync_r <= {scl_sync_r[0], serial_clock_line_i};
      sda_sync_r <= {sda_sync_r[0], serial_data_line_i};
    end
  end

  // filter only in high-speed mode; standard mode ignores the bit
  assign filter_on = cfg_r.speed_mode_select && cfg_r.noise_filter_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_stab_r <= 3'h0;
      sda_stab_r <= 3'h0;
    end else begin
      // cleared while disabled so the count cannot wrap and delay the first accepted level
      scl_stab_r <= (!enable_r || scl_sync_r[1] == clock_line_level_r) ? 3'h0 : scl_stab_r + 3'h1;
      sda_stab_r <= (!enable_r || sda_sync_r[1] == data_line_level_r) ? 3'h0 : sda_stab_r + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_line_level_r <= 1'b0;
      data_line_level_r <= 1'b0;
    end else if (!enable_r) begin
      clock_line_level_r <= 1'b0;
      data_line_level_r <= 1'b0;
    end else begin
      if (!filter_on || scl_stab_r >= i2ccs_pkg::FILTER_CYCLES - 3'h1) begin
        clock_line_level_r <= scl_sync_r[1];
      end
      if (!filter_on || sda_stab_r >= i2ccs_pkg::FILTER_CYCLES - 3'h1) begin
        data_line_level_r <= sda_sync_r[1];
      end
    end
  end

  // ********************************************************
  // selection clock and serial clock generator
  // ********************************************************
  // generator watches the unfiltered line so the filter cannot shift the period
  i2ccs_pkg::i2ccs_div_t div;
  i2ccs_pkg::i2ccs_phase_t phase_r;
  logic [2:0] pre_r;
  logic [5:0] half_r;
  logic fw_tick;

  assign div = decode_div(cfg_r);
  assign fw_tick = (pre_r == div.prediv - 3'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 3'h0;
    end else if (!enable_r || !div.valid || fw_tick || phase_r == i2ccs_pkg::PH_IDLE) begin
      // held through idle so the first low half is as long as the later ones
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= i2ccs_pkg::PH_IDLE;
      half_r <= 6'h00;
    end else if (!enable_r || !div.valid) begin
      phase_r <= i2ccs_pkg::PH_IDLE;
      half_r <= 6'h00;
    end else begin
      unique case (phase_r)
        i2ccs_pkg::PH_IDLE: begin
          phase_r <= i2ccs_pkg::PH_LOW;
          half_r <= 6'h00;
        end
        i2ccs_pkg::PH_LOW: if (fw_tick) begin
          if (half_r == div.half - 6'h01) begin
            phase_r <= i2ccs_pkg::PH_HIGH;
            half_r <= 6'h00;
          end else begin
            half_r <= half_r + 6'h01;
          end
        end
        i2ccs_pkg::PH_HIGH: if (fw_tick && scl_sync_r[1]) begin
          if (half_r == div.half - 6'h01) begin
            phase_r <= i2ccs_pkg::PH_LOW;
            half_r <= 6'h00;
          end else begin
            half_r <= half_r + 6'h01;
          end
        end
        default: phase_r <= i2ccs_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe <= 1'b0;
    end else begin
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe <= (phase_r == i2ccs_pkg::PH_LOW);
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  logic [8:0] low_len_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_len_r <= 9'h000;
    end else begin
      low_len_r <= (phase_r == i2ccs_pkg::PH_LOW) ? low_len_r + 9'h001 : 9'h000;
    end
  end

  sequence s_enable_on;
    $rose(enable_r);
  endsequence

  sequence s_low_ends;
    (phase_r == i2ccs_pkg::PH_LOW) ##1 (phase_r == i2ccs_pkg::PH_HIGH);
  endsequence

  a_reset_clears_cfg: assert property (@(posedge hclk) $rose(hresetn) |-> cfg_r == '0 && !enable_r)
    else $error("config not cleared by reset");
  a_exp_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(addr_phase && !hwrite && haddr == i2ccs_pkg::CLK_EXP_OFFSET) |-> hrdata[31:1] == 31'h0)
    else $error("expansion register upper bits not zero");
  a_sel_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(addr_phase && !hwrite && haddr == i2ccs_pkg::CLK_SEL_OFFSET) |-> hrdata[7:6] == 2'b00)
    else $error("clock selection bits 7 and 6 not zero");
  a_level_off_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable_r ##1 !enable_r |-> !clock_line_level_r && !data_line_level_r)
    else $error("line level bits set while disabled");
  a_clk_level_track: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable_r && !filter_on) ##1 (enable_r && !filter_on) |-> clock_line_level_r == $past(scl_sync_r[1]))
    else $error("clock level bit does not follow line");
  a_data_level_filter: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable_r && filter_on && $changed(sda_sync_r[1])) |=> data_line_level_r == $past(data_line_level_r))
    else $error("filter passed a one-sample data change");
  a_divider_held: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enable_on |-> pre_r == 3'h0 && phase_r == i2ccs_pkg::PH_IDLE)
    else $error("divider not restarted on enable");
  a_low_half_len: assert property (@(posedge hclk) disable iff (!hresetn)
    s_low_ends |-> $past(low_len_r) + 9'h001 == 9'(div.half) * 9'(div.prediv))
    else $error("low phase length wrong");
  a_prohibited_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_r.divide_code_high && cfg_r.divide_code_low) ##1 (cfg_r.divide_code_high && cfg_r.divide_code_low)
    |-> phase_r == i2ccs_pkg::PH_IDLE && !serial_clock_line_oe)
    else $error("prohibited divide code runs the clock");
  a_filter_no_freq: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r.speed_mode_select |-> decode_div(cfg_r) == decode_div(cfg_r ^ 5'b00100))
    else $error("filter bit changes the divider");
  a_stretch_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == i2ccs_pkg::PH_HIGH && !scl_sync_r[1] && enable_r && div.valid) |=> $stable(half_r))
    else $error("generator counts while clock held low");

endmodule

`default_nettype wire

// ---- i2ccs_bus_model.sv ----
// far side of the serial lines: pull-ups plus a slave that can stretch the clock low
// assumes the design drives the clock line open drain; hclk only times the stretch
`default_nettype none

module i2ccs_bus_model (
  // timing
  input wire logic hclk,
  // design drive
  input wire logic clock_oe,
  input wire logic clock_o,
  // scenario controls
  input wire logic stretch_en,
  input wire logic [7:0] stretch_cycles,
  input wire logic clock_hold,
  input wire logic data_low,
  // resolved line levels
  output logic clock_line,
  output logic data_line
);
  timeunit 1ns;
  timeprecision 100ps;

  logic oe_d_r;
  logic [7:0] hold_r = 8'h00;
  logic released;

  // stretch starts in the very cycle the master lets go, so no high glitch shows
  assign released = stretch_en && oe_d_r && !clock_oe;

  always_ff @(posedge hclk) begin
    oe_d_r <= clock_oe;
  end

  always_ff @(posedge hclk) begin
    if (released) begin
      hold_r <= stretch_cycles;
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end
  end

  // pull-ups: a line nobody pulls low reads high
  assign clock_line = !(clock_oe && !clock_o) && !released && (hold_r == 8'h00) && !clock_hold;
  assign data_line = !data_low;
endmodule

`default_nettype wire

// ---- i2ccs_top_tb_top.sv ----
// self-checking bench: register access over ahb-lite, line sensing, clock periods
// assumes i2ccs_bus_model as the far side and a 250 MHz hclk
`default_nettype none

module i2ccs_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic hreadyout, scl_o, scl_oe, scl_i, sda_i;
  logic stretch_en, clock_hold, data_low;
  logic [7:0] stretch_cycles;
  int failures = 0;
  int comparisons = 0;

  assign hready = hreadyout;

  i2ccs_top i2ccs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_clock_line_i(scl_i), .serial_clock_line_o(scl_o),
    .serial_clock_line_oe(scl_oe), .serial_data_line_i(sda_i));

  i2ccs_bus_model i2ccs_bus_model_inst (.hclk(hclk), .clock_oe(scl_oe), .clock_o(scl_o),
    .stretch_en(stretch_en), .stretch_cycles(stretch_cycles), .clock_hold(clock_hold),
    .data_low(data_low), .clock_line(scl_i), .data_line(sda_i));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_rdy();
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    check(hrdata, {24'h000000, exp});
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one configuration: program while disabled, enable, time the generated clock
  task automatic period(input logic [7:0] exp, input logic [7:0] cfg, input int full, input int extra);
    int n, lo, per;
    bus(i2ccs_pkg::CLK_EXP_OFFSET, 1'b1, exp);
    bus(i2ccs_pkg::CLK_SEL_OFFSET, 1'b1, cfg);
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h80);
    n = 0;
    while (scl_oe !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (full == 0) begin
      check({31'h0, scl_oe}, 32'h0);
    end else begin
      lo = 0;
      while (scl_oe === 1'b1 && lo < 400) begin
        @(posedge hclk);
        lo++;
      end
      per = lo;
      while (scl_oe !== 1'b1 && per < 1000) begin
        @(posedge hclk);
        per++;
      end
      check(32'(lo), 32'(full / 2));
      check({31'h0, per >= full + extra && per <= full + extra + 6}, 32'h1);
      check({31'h0, scl_o}, 32'h0);
      // a stuck generator has already been counted by the checks above
      if (lo >= 400 || per >= 1000) begin
        wrap_up();
      end
    end
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h00);
  endtask

  // ********************************************************
  // period table: expansion, selection, expected m times pre-divide (0 = idle)
  // ********************************************************
  logic [7:0] t_exp [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01};
  logic [7:0] t_cfg [12] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h08, 8'h0E, 8'h03, 8'h00, 8'h0B};
  int t_full [12] = '{88, 172, 344, 48, 48, 96, 48, 24, 48, 0, 0, 0};

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    stretch_en = 1'b0;
    stretch_cycles = 8'h3C;
    clock_hold = 1'b0;
    data_low = 1'b0;
    cycles(8);
    hresetn <= 1'b1;
    cycles(2);

    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h00);
    rd_chk(i2ccs_pkg::CLK_EXP_OFFSET, 8'h00);
    rd_chk(16'h0010, 8'h00);
    $display("test reset_values done");

    bus(i2ccs_pkg::CLK_EXP_OFFSET, 1'b1, 8'hFF);
    rd_chk(i2ccs_pkg::CLK_EXP_OFFSET, 8'h01);
    bus(i2ccs_pkg::CLK_SEL_OFFSET, 1'b1, 8'hFF);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h0F);
    bus(i2ccs_pkg::CLK_EXP_OFFSET, 1'b1, 8'h00);
    $display("test register_access done");

    // prohibited code keeps the generator idle, so the clock line stays ours to steer
    bus(i2ccs_pkg::CLK_SEL_OFFSET, 1'b1, 8'h03);
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h80);
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h33);
    data_low <= 1'b1;
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h23);
    data_low <= 1'b0;
    clock_hold <= 1'b1;
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h13);
    clock_hold <= 1'b0;
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h00);
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h03);
    $display("test line_levels done");

    for (int i = 0; i < 12; i++) begin
      period(t_exp[i], t_cfg[i], t_full[i], 0);
    end
    $display("test clock_periods done");

    stretch_en <= 1'b1;
    period(8'h01, 8'h08, 24, 60);
    stretch_en <= 1'b0;
    $display("test clock_stretch done");

    // high-speed with filter, prohibited code so the clock line stays high
    bus(i2ccs_pkg::CLK_SEL_OFFSET, 1'b1, 8'h0F);
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h80);
    cycles(8);
    data_low <= 1'b1;
    cycles(1);
    data_low <= 1'b0;
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h3F);
    data_low <= 1'b1;
    cycles(8);
    rd_chk(i2ccs_pkg::CLK_SEL_OFFSET, 8'h2F);
    data_low <= 1'b0;
    bus(i2ccs_pkg::IF_CTRL_OFFSET, 1'b1, 8'h00);
    $display("test data_filter done");
    wrap_up();
  end
endmodule

`default_nettype wire
